/* File: core/ppa_top.sv */
`timescale 1ns/1ns
// Operation
// - Bits 31 to 16 of the address register read back as zero.
// - Function 10 or 01: bit 15 drives second chip select active when 1.
// - Function 00: bit 15 is address bit 15 on the address lines.
// - Only function 10: bit 14 drives first chip select active when 1.
// - Function 00 or 01: bit 14 is address bit 14.
// - Bits 13 to 0 always hold low address driven on the lines.
// - Per mode, address steps up, down or holds after each completed cycle.
// - Bits used as chip selects never take part in stepping.
module ppa_top
  import ppa_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cycle_done,
  output logic      [15:0] ext_addr,
  output logic             first_select,
  output logic             second_select
);
  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic logic sel2_on(input logic [1:0] f);
    sel2_on = (f == PPA_SELF_TWO) || (f == PPA_SELF_ONE);
  endfunction

  function automatic logic sel1_on(input logic [1:0] f);
    sel1_on = (f == PPA_SELF_TWO);
  endfunction

  typedef struct packed {
    ppa_apb_st_t st;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic [15:0] ext;
    logic        cs1;
    logic        cs2;
  } ppa_state_t;

  ppa_state_t s_q;
  ppa_state_t s_d;

  logic [15:0] addr_q;
  logic [15:0] addr_wd;
  logic        addr_we;
  logic [3:0]  ctrl_q;
  logic        ctrl_we;
  logic [1:0]  self_f;
  logic [1:0]  step_f;
  logic        setup;
  logic        hit_addr;
  logic        hit_ctrl;
  logic        xfer_end;
  logic        wr_addr;
  logic        wr_ctrl;
  logic [15:0] stepped;
  logic [15:0] keep_mask;

  assign self_f   = ctrl_q[PPA_SELF_LSB +: 2];
  assign step_f   = ctrl_q[PPA_STEP_LSB +: 2];
  assign setup    = psel && !penable && (s_q.st == PPA_IDLE);
  assign hit_addr = (paddr == PPA_ADDR_OFS);
  assign hit_ctrl = (paddr == PPA_CTRL_OFS);
  // Writes land at the completing access edge, not at setup
  assign xfer_end = psel && penable && s_q.ready;
  assign wr_addr  = xfer_end && pwrite && hit_addr;
  assign wr_ctrl  = xfer_end && pwrite && hit_ctrl;

  ////////////////////////////////////////////////////////////////////////////
  // Step the address; select bits are frozen
  always_comb begin
    keep_mask = 16'h0000;
    if (sel2_on(self_f)) begin
      keep_mask[PPA_SEL2_BIT] = 1'b1;
    end
    if (sel1_on(self_f)) begin
      keep_mask[PPA_SEL1_BIT] = 1'b1;
    end
    case (step_f)
      PPA_STEP_INC: stepped = addr_q + 16'h0001;
      PPA_STEP_DEC: stepped = addr_q - 16'h0001;
      default:      stepped = addr_q;
    endcase
    stepped = (stepped & ~keep_mask) | (addr_q & keep_mask);
  end

  // Software write wins over a step in the same cycle
  always_comb begin
    addr_we = 1'b0;
    addr_wd = stepped;
    if (wr_addr) begin
      addr_we = 1'b1;
      addr_wd = pwdata[PPA_IMPL_W-1:0];
    end else if (cycle_done && step_f != PPA_STEP_HOLD) begin
      addr_we = 1'b1;
    end
  end

  assign ctrl_we = wr_ctrl;

  ppa_regword #(.W(16), .RST(PPA_ADDR_RST)) u_addr (
    .clk    (clk),
    .resetn (resetn),
    .we     (addr_we),
    .wdata  (addr_wd),
    .q      (addr_q)
  );

  ppa_regword #(.W(4), .RST(PPA_CTRL_RST)) u_ctrl (
    .clk    (clk),
    .resetn (resetn),
    .we     (ctrl_we),
    .wdata  (pwdata[3:0]),
    .q      (ctrl_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB slave and pin drive
  always_comb begin
    s_d = s_q;
    s_d.ready = 1'b0;
    s_d.slverr = 1'b0;
    case (s_q.st)
      PPA_IDLE: begin
        if (setup) begin
          s_d.st = PPA_DONE;
          s_d.ready = 1'b1;
          s_d.slverr = !(hit_addr || hit_ctrl);
          s_d.rdata = 32'h0000_0000;
          if (hit_addr) begin
            s_d.rdata = {16'h0000, addr_q};
          end else if (hit_ctrl) begin
            s_d.rdata = {28'h0000000, ctrl_q};
          end
        end
      end
      PPA_DONE: s_d.st = PPA_IDLE;
      default:  s_d.st = PPA_IDLE;
    endcase
    s_d.ext = {2'b00, addr_q[PPA_LOW_MSB:0]};
    if (!sel2_on(self_f)) begin
      s_d.ext[PPA_SEL2_BIT] = addr_q[PPA_SEL2_BIT];
    end
    if (!sel1_on(self_f)) begin
      s_d.ext[PPA_SEL1_BIT] = addr_q[PPA_SEL1_BIT];
    end
    s_d.cs2 = sel2_on(self_f) && addr_q[PPA_SEL2_BIT];
    s_d.cs1 = sel1_on(self_f) && addr_q[PPA_SEL1_BIT];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{st: PPA_IDLE, rdata: 32'h0, ready: 1'b0, slverr: 1'b0,
               ext: 16'h0, cs1: 1'b0, cs2: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata        = s_q.rdata;
  assign pready        = s_q.ready;
  assign pslverr       = s_q.slverr;
  assign ext_addr      = s_q.ext;
  assign first_select  = s_q.cs1;
  assign second_select = s_q.cs2;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_UPPER_ZERO: assert property (@(posedge clk) disable iff (!resetn)
    pready |-> prdata[31:16] == 16'h0000) else $error("upper bits not zero");
  AST_CS2: assert property (@(posedge clk) disable iff (!resetn)
    sel2_on(self_f) && addr_q[15] && $stable(ctrl_q) |=> second_select)
    else $error("second select not active");
  AST_A15: assert property (@(posedge clk) disable iff (!resetn)
    self_f == PPA_SELF_NONE
    |=> ext_addr[15] == $past(addr_q[15]) && !second_select)
    else $error("bit 15 not driven as address");
  AST_CS1: assert property (@(posedge clk) disable iff (!resetn)
    !sel1_on(self_f) |=> !first_select) else $error("first select wrongly on");
  AST_A14: assert property (@(posedge clk) disable iff (!resetn)
    self_f == PPA_SELF_ONE |=> ext_addr[14] == $past(addr_q[14]))
    else $error("bit 14 not driven as address");
  AST_LOW: assert property (@(posedge clk) disable iff (!resetn)
    1'b1 |=> ext_addr[13:0] == $past(addr_q[13:0]))
    else $error("low address wrong");
  AST_INC: assert property (@(posedge clk) disable iff (!resetn)
    cycle_done && !wr_addr && step_f == PPA_STEP_INC &&
    self_f == PPA_SELF_NONE |=> addr_q == $past(addr_q) + 16'h0001)
    else $error("no increment");
  AST_FREEZE: assert property (@(posedge clk) disable iff (!resetn)
    cycle_done && !wr_addr && self_f == PPA_SELF_TWO
    |=> addr_q[15:14] == $past(addr_q[15:14]))
    else $error("select bits stepped");
  AST_FREEZE1: assert property (@(posedge clk) disable iff (!resetn)
    cycle_done && !wr_addr && self_f == PPA_SELF_ONE
    |=> addr_q[15] == $past(addr_q[15])) else $error("select bit stepped");
  AST_DEC: assert property (@(posedge clk) disable iff (!resetn)
    cycle_done && !wr_addr && step_f == PPA_STEP_DEC &&
    self_f == PPA_SELF_NONE |=> addr_q == $past(addr_q) - 16'h0001)
    else $error("no decrement");
  AST_HOLD: assert property (@(posedge clk) disable iff (!resetn)
    cycle_done && !wr_addr && step_f == PPA_STEP_HOLD
    |=> addr_q == $past(addr_q)) else $error("address moved on hold");
  AST_WR: assert property (@(posedge clk) disable iff (!resetn)
    wr_addr |=> addr_q == $past(pwdata[15:0]))
    else $error("address write lost");
  AST_CS2_OFF: assert property (@(posedge clk) disable iff (!resetn)
    sel2_on(self_f) && !addr_q[15] |=> !second_select)
    else $error("second select wrongly on");
  AST_CS1_ON: assert property (@(posedge clk) disable iff (!resetn)
    sel1_on(self_f) && addr_q[14] |=> first_select)
    else $error("first select not active");
  AST_RST: assert property (@(posedge clk)
    $rose(resetn) |-> addr_q == 16'h0000 && !first_select && !second_select)
    else $error("reset value wrong");
endmodule

/* File: core/ppa_pkg.sv */
package ppa_pkg;
  // Register byte offsets on the APB slave
  localparam logic [7:0] PPA_ADDR_OFS = 8'h00;
  localparam logic [7:0] PPA_CTRL_OFS = 8'h04;
  // Address register fields
  localparam int PPA_SEL2_BIT = 15;
  localparam int PPA_SEL1_BIT = 14;
  localparam int PPA_LOW_MSB  = 13;
  localparam int PPA_IMPL_W   = 16;
  localparam logic [15:0] PPA_ADDR_RST = 16'h0000;
  // Control register fields
  localparam int PPA_SELF_LSB = 0;
  localparam int PPA_STEP_LSB = 2;
  localparam logic [3:0] PPA_CTRL_RST = 4'h0;
  // Select function field codes
  localparam logic [1:0] PPA_SELF_NONE = 2'h0;
  localparam logic [1:0] PPA_SELF_ONE  = 2'h1;
  localparam logic [1:0] PPA_SELF_TWO  = 2'h2;
  // Address step mode codes
  localparam logic [1:0] PPA_STEP_HOLD = 2'h0;
  localparam logic [1:0] PPA_STEP_INC  = 2'h1;
  localparam logic [1:0] PPA_STEP_DEC  = 2'h2;
  // APB access answer latency in cycles after setup
  localparam int PPA_APB_WAIT = 1;

  typedef enum logic [1:0] {
    PPA_IDLE = 2'b01,
    PPA_DONE = 2'b10
  } ppa_apb_st_t;
endpackage

/* File: core/ppa_regword.sv */
`timescale 1ns/1ns
// Small storage word with registered read data
module ppa_regword
  import ppa_pkg::*;
#(
  parameter int             W   = 16,
  parameter logic [W-1:0]   RST = '0
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         we,
  input  wire logic [W-1:0] wdata,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] val;
  } ppa_word_t;

  ppa_word_t s_q;
  ppa_word_t s_d;

  // Load when enabled
  always_comb begin
    s_d = s_q;
    if (we) begin
      s_d.val = wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{val: RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.val;
endmodule

/* File: tb/ppa_far_dev.sv */
`timescale 1ns/1ns
// External memory model: finishes one bus cycle two clocks after a request
module ppa_far_dev (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic req,
  output logic      cycle_done
);
  logic [1:0] pipe_q;
  // Fixed latency, no early or late completion
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pipe_q <= 2'h0;
    end else begin
      pipe_q <= {pipe_q[0], req};
    end
  end
  // Completion pulse as long as the request, two clocks late
  assign cycle_done = pipe_q[1];
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ns
module testbench
  import ppa_pkg::*;
;
  logic        clk, resetn, psel, penable, pwrite, req, err;
  logic        pready, pslverr, cycle_done, f_sel, s_sel;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] ext_addr;
  int          mismatches, n_tests, cyc;
  // Step table: control word, start address, expected address
  logic [3:0]  sc[6] = '{4'h4, 4'h8, 4'h0, 4'hc, 4'h6, 4'h9};
  logic [15:0] sa[6] = '{16'hffff, 16'h0, 16'h1234, 16'h1234,
                         16'hffff, 16'h8000};
  logic [15:0] se[6] = '{16'h0, 16'hffff, 16'h1234, 16'h1234,
                         16'hc000, 16'hffff};

  ppa_top dut_u (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cycle_done(cycle_done), .ext_addr(ext_addr),
    .first_select(f_sel), .second_select(s_sel));
  ppa_far_dev far_u (.clk(clk), .resetn(resetn), .req(req),
    .cycle_done(cycle_done));

  ////////////////////////////////////////////////////////////////////////
  // One APB transfer; idle edge first so back-to-back calls never clash
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string n, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic rdc(input string n, input logic [7:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask

  // Pins follow the register one cycle late; two edges leave margin
  task automatic pins(input logic [15:0] a, input logic f, s);
    repeat (2) @(posedge clk);
    chk("pins", {14'h0, f, s, a}, {14'h0, f_sel, s_sel, ext_addr});
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Hang guard, far above the length of the sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      complete_run();
    end
  end

  initial begin
    {resetn, psel, penable, pwrite, req} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rdc("addr_rst", PPA_ADDR_OFS, 32'h0);
    rdc("ctrl_rst", PPA_CTRL_OFS, 32'h0);
    pins(16'h0, 1'b0, 1'b0);
    $display("test reset done");
    apb(1'b1, PPA_ADDR_OFS, 32'hffffffff);
    rdc("addr_upper", PPA_ADDR_OFS, 32'h0000ffff);
    // Functions 00, 01 and 10: enabled selects active, their bits off the lines
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, PPA_CTRL_OFS, m);
      pins(16'hffff >> m, m == 2, m != 0);
    end
    apb(1'b1, PPA_CTRL_OFS, 32'h3);
    pins(16'hffff, 1'b0, 1'b0);
    apb(1'b1, PPA_ADDR_OFS, 32'h0);
    pins(16'h0, 1'b0, 1'b0);
    $display("test select done");
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, PPA_CTRL_OFS, {28'h0, sc[i]});
      apb(1'b1, PPA_ADDR_OFS, {16'h0, sa[i]});
      @(posedge clk);
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      repeat (4) @(posedge clk);
      rdc("step", PPA_ADDR_OFS, {16'h0, se[i]});
    end
    $display("test step done");
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped_rd", 32'h0, rd);
    chk("unmapped_err", 32'h1, {31'h0, err});
    apb(1'b1, 8'h10, 32'h5555);
    rdc("addr_kept", PPA_ADDR_OFS, {16'h0, se[5]});
    $display("test unmapped done");
    complete_run();
  end
endmodule
